// *** verilog/pscp_pkg.sv ***
// constants, states and state records of the passive serial configuration port
`default_nettype none
package pscp_pkg;
   localparam int unsigned REF_PERIOD_PS  = 8000;
   localparam int unsigned INIT_TIME_NS   = 6000;
   localparam int unsigned INIT_CYCLES    = (INIT_TIME_NS * 1000 + REF_PERIOD_PS - 1) / REF_PERIOD_PS;
   localparam int unsigned INIT_W         = 10;
   localparam int unsigned LINE_SETTLE    = 3;
   localparam int unsigned FRAME_W        = 12;
   localparam int unsigned FRAME_BYTES_DEF = 16;
   localparam int unsigned BYTE_W         = 8;
   localparam int unsigned FIFO_DEPTH     = 16;
   localparam logic [7:0]  SYNC_BYTE      = 8'hA5;
   localparam logic [2:0]  BIT_LAST       = 3'h7;

   typedef enum logic [2:0] {
      ST_IDLE      = 3'h0,
      ST_LOAD      = 3'h1,
      ST_WAIT_DONE = 3'h2,
      ST_INIT      = 3'h3,
      ST_USER      = 3'h4,
      ST_ERROR     = 3'h5,
      ST_HALT      = 3'h6
   } pscp_state_e;

   typedef struct packed {
      pscp_state_e        state;
      logic [FRAME_W-1:0] byte_cnt;
      logic [INIT_W-1:0]  init_cnt;
      logic               req_prev;
      logic               fault_oe;
      logic               done_oe;
      logic               chain_out_n;
      logic               user_mode;
      logic               data_user;
      logic               upper_cfg;
      logic               link_active;
      logic               line_lo;
   } pscp_ref_s;

   typedef struct packed {
      logic [BYTE_W-1:0] shreg;
      logic [2:0]        bit_cnt;
      logic              overrun;
   } pscp_link_s;
endpackage
`default_nettype wire

// *** verilog/pscp_sync.sv ***
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module pscp_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } pscp_sync_s;

   pscp_sync_s st_r;
   pscp_sync_s st_nxt;

   always_comb begin
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2;
endmodule // pscp_sync
`default_nettype wire

// *** verilog/pscp_fifo.sv ***
// dual-clock fifo with gray-coded pointers
`timescale 1ns/1ps
`default_nettype none
module pscp_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             wr_clk,
   input  wire logic             rd_clk,
   input  wire logic             reset,
   input  wire logic             wr_valid,
   output logic                  wr_ready,
   input  wire logic [WIDTH-1:0] wr_data,
   output logic                  rd_valid,
   input  wire logic             rd_ready,
   output logic      [WIDTH-1:0] rd_data
);
   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] bin;
      logic [AW:0] gray;
   } pscp_ptr_s;

   pscp_ptr_s       w_r;
   pscp_ptr_s       w_nxt;
   pscp_ptr_s       r_r;
   pscp_ptr_s       r_nxt;
   logic [AW:0]     rgray_w;
   logic [AW:0]     wgray_r;
   logic [WIDTH-1:0] mem [DEPTH];

   function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction

   // full when write gray equals read gray with top two bits inverted
   assign wr_ready = (w_r.gray != {~rgray_w[AW:AW-1], rgray_w[AW-2:0]});
   assign rd_valid = (r_r.gray != wgray_r);
   assign rd_data  = mem[r_r.bin[AW-1:0]];

   always_comb begin
      w_nxt = w_r;
      if (wr_valid && wr_ready) begin
         w_nxt.bin  = w_r.bin + 1'b1;
         w_nxt.gray = bin2gray(w_nxt.bin);
      end
      r_nxt = r_r;
      if (rd_valid && rd_ready) begin
         r_nxt.bin  = r_r.bin + 1'b1;
         r_nxt.gray = bin2gray(r_nxt.bin);
      end
   end

   always_ff @(posedge wr_clk or posedge reset) begin
      if (reset) begin
         w_r <= '0;
      end else begin
         w_r <= w_nxt;
      end
   end

   always_ff @(posedge wr_clk) begin
      if (wr_valid && wr_ready) begin
         mem[w_r.bin[AW-1:0]] <= wr_data;
      end
   end

   always_ff @(posedge rd_clk or posedge reset) begin
      if (reset) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

   pscp_sync #(.W(AW + 1)) u_rgray_sync (
      .clk   (wr_clk),
      .reset (reset),
      .d     (r_r.gray),
      .q     (rgray_w)
   );

   pscp_sync #(.W(AW + 1)) u_wgray_sync (
      .clk   (rd_clk),
      .reset (reset),
      .d     (w_r.gray),
      .q     (wgray_r)
   );
endmodule // pscp_fifo
`default_nettype wire

// *** verilog/pscp_top.sv ***
// passive serial configuration port, device side
// Behaviour
// (R1) data pins become user pins after configuration
// (R2) host starts cycle with request rising edge
// (R3) one serial bit accepted per clock
// (R4) host clocks until completion line high
// (R5) no self restart after error
// (R6) initialization needs no user start-up clock
// (R7) chain enable output feeds next device
// (R8) chained devices initialize together
// (R9) any shared fault halts whole chain; the code reacts to it only in ST_LOAD after line settle and in ST_WAIT_DONE
// (R10) selector logic passes fault and completion both ways
// (R11) on error drive fault low, reset logic
// (R12) release completion line after all data
// (R13) host shifts each byte LSB first
// (R14) sample serial data on clock rising edge
`timescale 1ns/1ps
`default_nettype none
module pscp_top #(
   parameter logic [pscp_pkg::FRAME_W-1:0] FRAME_BYTES = pscp_pkg::FRAME_W'(pscp_pkg::FRAME_BYTES_DEF)
) (
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic config_clock,
   input  wire logic config_request_n,
   input  wire logic serial_data_in,
   input  wire logic chain_enable_in_n,
   input  wire logic fault_status_in,
   input  wire logic config_complete_in,
   output logic      fault_status_out,
   output logic      fault_status_oe,
   output logic      config_complete_out,
   output logic      config_complete_oe,
   output logic      chain_enable_out_n,
   output logic      user_mode,
   output logic      data_pins_user,
   output logic      upper_data_cfg
);
   import pscp_pkg::*;

   pscp_ref_s         r;
   pscp_ref_s         r_nxt;
   pscp_link_s        l_r;
   pscp_link_s        l_nxt;
   logic [3:0]        pins_s;
   logic              req_s;
   logic              chain_in_s;
   logic              fault_s;
   logic              done_s;
   logic              ovr_s;
   logic              act_l;
   logic              wr_valid;
   logic              wr_ready;
   logic [BYTE_W-1:0] wr_data;
   logic              rd_valid;
   logic              rd_ready;
   logic [BYTE_W-1:0] rd_data;
   logic              bad_head;
   logic              last_byte;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers into the ref_clk domain

   pscp_sync #(.W(4)) u_pin_sync (
      .clk   (ref_clk),
      .reset (reset),
      .d     ({config_request_n, chain_enable_in_n, fault_status_in, config_complete_in}),
      .q     (pins_s)
   );

   assign req_s      = pins_s[3];
   assign chain_in_s = pins_s[2];
   assign fault_s    = pins_s[1];
   assign done_s     = pins_s[0];

   pscp_sync #(.W(1)) u_ovr_sync (
      .clk   (ref_clk),
      .reset (reset),
      .d     (l_r.overrun),
      .q     (ovr_s)
   );

   ////////////////////////////////////////////////////////////////////////////
   // link side, runs on the host's configuration clock

   pscp_sync #(.W(1)) u_act_sync (
      .clk   (config_clock),
      .reset (reset),
      .d     (r.link_active),
      .q     (act_l)
   );

   // byte goes into the fifo on the edge of its eighth bit: the clock may
   // stop right after the last bit, so no later edge can be relied on
   assign wr_valid = act_l && (l_r.bit_cnt == BIT_LAST);
   assign wr_data  = {serial_data_in, l_r.shreg[BYTE_W-1:1]}; // [R13]

   always_comb begin
      l_nxt = l_r;
      if (!act_l) begin
         // limitation: a stopped clock leaves partial bits until it runs again
         l_nxt = '0;
      end else begin
         l_nxt.shreg   = {serial_data_in, l_r.shreg[BYTE_W-1:1]}; // [R3] [R13]
         l_nxt.bit_cnt = l_r.bit_cnt + 3'h1; // [R3]
         if (wr_valid && !wr_ready) begin
            l_nxt.overrun = 1'b1;
         end
      end
   end

   always_ff @(posedge config_clock or posedge reset) begin // [R14]
      if (reset) begin
         l_r <= '0;
      end else begin
         l_r <= l_nxt;
      end
   end

   pscp_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .wr_clk   (config_clock),
      .rd_clk   (ref_clk),
      .reset    (reset),
      .wr_valid (wr_valid),
      .wr_ready (wr_ready),
      .wr_data  (wr_data),
      .rd_valid (rd_valid),
      .rd_ready (rd_ready),
      .rd_data  (rd_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // configuration control, ref_clk domain

   assign bad_head  = rd_valid && (r.byte_cnt == '0) && (rd_data != SYNC_BYTE);
   assign last_byte = rd_valid && (r.byte_cnt == FRAME_BYTES - 1'b1);

   always_comb begin
      r_nxt          = r;
      rd_ready       = 1'b0;
      r_nxt.req_prev = req_s;
      r_nxt.line_lo  = 1'b0;
      r_nxt.upper_cfg = 1'b0; // [R1] serial mode never borrows upper pins
      case (r.state)
         ST_IDLE: begin
            rd_ready       = 1'b1;
            r_nxt.byte_cnt = '0;
            r_nxt.init_cnt = '0;
            if (req_s && !r.req_prev) begin // [R2]
               r_nxt.state    = ST_LOAD;
               r_nxt.fault_oe = 1'b1;
            end
         end
         ST_LOAD: begin
            rd_ready          = 1'b1;
            // synced fault line lags our own release; ignore it until settled
            if (r.init_cnt != INIT_W'(LINE_SETTLE)) begin
               r_nxt.init_cnt = r.init_cnt + 1'b1;
            end else if (!fault_s) begin // [R9]
               r_nxt.state       = ST_HALT;
               r_nxt.link_active = 1'b0;
            end else if (ovr_s || bad_head) begin // [R11]
               r_nxt.state       = ST_ERROR;
               r_nxt.fault_oe    = 1'b0;
               r_nxt.link_active = 1'b0;
               r_nxt.byte_cnt    = '0;
            end else if (last_byte) begin // [R12]
               r_nxt.state       = ST_WAIT_DONE;
               r_nxt.init_cnt    = '0;
               r_nxt.done_oe     = 1'b1;
               r_nxt.chain_out_n = 1'b0; // [R7]
               r_nxt.link_active = 1'b0;
            end else begin
               r_nxt.link_active = !chain_in_s; // [R7]
               if (rd_valid) begin
                  r_nxt.byte_cnt = r.byte_cnt + 1'b1;
               end
            end
         end
         ST_WAIT_DONE: begin
            // the wired completion line rises only when every device let go
            if (!fault_s) begin // [R9]
               r_nxt.state = ST_HALT;
            end else if (done_s) begin // [R8]
               r_nxt.state = ST_INIT;
            end
         end
         ST_INIT: begin
            // timed on the internal clock, no user start-up clock needed
            if (r.init_cnt == INIT_W'(INIT_CYCLES - 1)) begin // [R6]
               r_nxt.state     = ST_USER;
               r_nxt.user_mode = 1'b1;
               r_nxt.data_user = 1'b1; // [R1]
            end else begin
               r_nxt.init_cnt = r.init_cnt + 1'b1;
            end
         end
         ST_USER: begin
            r_nxt.state = ST_USER;
         end
         ST_ERROR, ST_HALT: begin
            // stale bytes are drained; only the host may restart
            rd_ready = 1'b1; // [R5]
         end
         default: begin
            r_nxt.state = ST_IDLE;
         end
      endcase
      if (!req_s) begin
         r_nxt.state       = ST_IDLE;
         r_nxt.fault_oe    = 1'b0;
         r_nxt.done_oe     = 1'b0;
         r_nxt.chain_out_n = 1'b1;
         r_nxt.user_mode   = 1'b0;
         r_nxt.data_user   = 1'b0;
         r_nxt.link_active = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         r.state       <= ST_IDLE;
         r.byte_cnt    <= '0;
         r.init_cnt    <= '0;
         r.req_prev    <= 1'b0;
         r.fault_oe    <= 1'b0;
         r.done_oe     <= 1'b0;
         r.chain_out_n <= 1'b1;
         r.user_mode   <= 1'b0;
         r.data_user   <= 1'b0;
         r.upper_cfg   <= 1'b0;
         r.link_active <= 1'b0;
         r.line_lo     <= 1'b0;
      end else begin
         r <= r_nxt;
      end
   end

   assign fault_status_out    = r.line_lo;
   assign fault_status_oe     = r.fault_oe;
   assign config_complete_out = r.line_lo;
   assign config_complete_oe  = r.done_oe;
   assign chain_enable_out_n  = r.chain_out_n;
   assign user_mode           = r.user_mode;
   assign data_pins_user      = r.data_user;
   assign upper_data_cfg      = r.upper_cfg;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   a_start_on_rise: assert property ( // [R2]
      (r.state == ST_IDLE && req_s && !r.req_prev) |=> (r.state == ST_LOAD && fault_status_oe))
      else $error("request rise did not start loading");

   a_error_drive_low: assert property ( // [R11]
      (r.state == ST_LOAD && req_s && r.init_cnt == INIT_W'(LINE_SETTLE) && fault_s && bad_head)
      |=> (r.state == ST_ERROR && !fault_status_oe && !r.link_active) ##1 (r.byte_cnt == '0))
      else $error("bad header did not drive fault low");

   a_no_auto_restart: assert property ( // [R5]
      (r.state == ST_ERROR && req_s) |=> (r.state == ST_ERROR && !fault_status_oe))
      else $error("device left error state on its own");

   a_chain_fault_halt: assert property ( // [R9]
      (r.state == ST_LOAD && req_s && r.init_cnt == INIT_W'(LINE_SETTLE) && !fault_s)
      |=> (r.state == ST_HALT && fault_status_oe && !r.link_active))
      else $error("shared fault did not halt loading");

   a_done_release: assert property ( // [R12]
      (r.state == ST_LOAD && req_s && r.init_cnt == INIT_W'(LINE_SETTLE) && fault_s && !ovr_s && !bad_head
       && last_byte)
      |=> (config_complete_oe && !chain_enable_out_n))
      else $error("completion line not released after last byte");

   a_init_together: assert property ( // [R8]
      (r.state == ST_WAIT_DONE) ##1 (r.state == ST_INIT) |-> $past(done_s))
      else $error("initialization began before completion line high");

   a_init_length: assert property ( // [R6]
      (r.state == ST_INIT && req_s && r.init_cnt == INIT_W'(INIT_CYCLES - 1))
      |=> (r.state == ST_USER && user_mode && $past(r.init_cnt) == INIT_W'(INIT_CYCLES - 1)))
      else $error("initialization length wrong");

   a_user_pins: assert property ( // [R1]
      $rose(user_mode) |-> (data_pins_user && !upper_data_cfg && $past(r.state) == ST_INIT))
      else $error("data pins not handed to user");

   a_chain_out: assert property ( // [R7]
      !chain_enable_out_n |-> (r.state inside {ST_WAIT_DONE, ST_INIT, ST_USER, ST_HALT}))
      else $error("chain enable out active while own data pending");

   a_lsb_first: assert property ( // [R3] [R13] [R14]
      @(posedge config_clock) disable iff (reset)
      (act_l && l_r.bit_cnt == BIT_LAST) |-> (wr_data[0] == $past(serial_data_in, 7)))
      else $error("serial bit order wrong");

   c_user_mode: cover property ($rose(user_mode));
   c_error: cover property ($rose(r.state == ST_ERROR));
   c_halt: cover property ($rose(r.state == ST_HALT));
   c_overrun: cover property ($rose(ovr_s));
endmodule // pscp_top
`default_nettype wire

// *** test/pscp_host_model.sv ***
// host model driving configuration through a download cable
`timescale 1ns/1ps
`default_nettype none
module pscp_host_model (
   output logic      config_clock,
   output logic      config_request_n,
   output logic      serial_data_in,
   input  wire logic config_complete_line
);
   int gap_ns;

   initial begin
      config_clock     = 1'b0;
      config_request_n = 1'b0;
      serial_data_in   = 1'b1;
      gap_ns           = 0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock stands low between bits and frames
   task automatic pulse;
      #7.5 config_clock = 1'b1;
      #7.5 config_clock = 1'b0;
   endtask

   // data line released: pull-up holds it high
   task automatic idle(input int n);
      serial_data_in = 1'b1;
      repeat (n) pulse();
   endtask

   // flush edges while low clear the link side of any stale partial byte
   task automatic start_cfg;
      config_request_n = 1'b0;
      #50;
      idle(4);
      #100;
      config_request_n = 1'b1;
   endtask

   task automatic send(input logic [7:0] d, input int n);
      for (int i = 0; i < n; i++) begin
         serial_data_in = d[i];
         pulse();
         #(gap_ns);
      end
      serial_data_in = 1'b1;
   endtask

   task automatic run_until_done(input int n);
      for (int i = 0; i < n && config_complete_line !== 1'b1; i++) begin
         idle(1);
      end
   endtask
endmodule // pscp_host_model
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench of the passive serial configuration port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pscp_pkg::*;
   localparam logic [FRAME_W-1:0] NBYTES = 12'h002;

   logic ref_clk, reset, chain_in_n, ext_fault, ext_done_low;
   logic cfg_clk, req_n, sdata;
   logic f_out, f_oe, c_out, c_oe, chain_out_n, umode, dpu, upcfg;
   int   failures;
   int   samples_checked;
   // shared open-drain lines with pull-ups, other chain members may pull low
   // no selector in between: both lines pass both ways
   wire  fault_line = (f_oe ? 1'b1 : f_out) & ~ext_fault;
   wire  done_line  = (c_oe ? 1'b1 : c_out) & ~ext_done_low;

   pscp_top #(.FRAME_BYTES(NBYTES)) u_dut (
      .ref_clk(ref_clk), .reset(reset), .config_clock(cfg_clk), .config_request_n(req_n),
      .serial_data_in(sdata), .chain_enable_in_n(chain_in_n), .fault_status_in(fault_line),
      .config_complete_in(done_line), .fault_status_out(f_out), .fault_status_oe(f_oe),
      .config_complete_out(c_out), .config_complete_oe(c_oe), .chain_enable_out_n(chain_out_n),
      .user_mode(umode), .data_pins_user(dpu), .upper_data_cfg(upcfg));

   pscp_host_model u_host (
      .config_clock(cfg_clk), .config_request_n(req_n), .serial_data_in(sdata),
      .config_complete_line(done_line));

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // bounded wait on fault release (0), completion release (1) or user mode (2)
   task automatic wait_sig(input int sel, input logic val, input int n);
      logic s;
      for (int i = 0; i < n; i++) begin
         cyc(1);
         s = (sel == 0) ? f_oe : (sel == 1) ? c_oe : umode;
         if (s === val) break;
      end
   endtask

   task automatic restart;
      u_host.start_cfg();
      wait_sig(0, 1'b1, 20);
      chk("fault line released", 1'b1, f_oe);
      chk("user mode cleared", 1'b0, umode);
      // link goes active after line settle; two edges fill its synchroniser
      cyc(6);
      u_host.idle(2);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_chain_off;
      chain_in_n = 1'b1;
      u_host.start_cfg();
      cyc(10);
      u_host.idle(3);
      u_host.send(SYNC_BYTE, 8);
      u_host.send(8'h3C, 8);
      cyc(20);
      chk("done while chain off", 1'b0, c_oe);
      chk("chain out while off", 1'b1, chain_out_n);
      chain_in_n = 1'b0;
      $display("test chain_off done");
   endtask

   task automatic t_good;
      restart();
      u_host.send(SYNC_BYTE, 8);
      u_host.send(8'h3C, 7);
      cyc(20);
      chk("done one bit short", 1'b0, c_oe);
      chk("chain one bit short", 1'b1, chain_out_n);
      ext_done_low = 1'b1;
      u_host.send(8'h00, 1);
      wait_sig(1, 1'b1, 30);
      chk("done released", 1'b1, c_oe);
      chk("chain out active", 1'b0, chain_out_n);
      u_host.run_until_done(10);
      cyc(100);
      chk("user while line held", 1'b0, umode);
      ext_done_low = 1'b0;
      cyc(740);
      chk("user before init end", 1'b0, umode);
      chk("pins before init end", 1'b0, dpu);
      wait_sig(2, 1'b1, 30);
      chk("user mode reached", 1'b1, umode);
      chk("pins user defined", 1'b1, dpu);
      chk("upper pins unused", 1'b0, upcfg);
      $display("test good_frame done");
   endtask

   task automatic t_bad_header;
      restart();
      u_host.send(8'h5A, 8);
      wait_sig(0, 1'b0, 40);
      chk("fault driven", 1'b0, f_oe);
      u_host.send(8'h3C, 8);
      cyc(1500);
      chk("no self restart", 1'b0, f_oe);
      chk("done after error", 1'b0, c_oe);
      $display("test bad_header done");
   endtask

   task automatic t_shared_fault;
      restart();
      u_host.gap_ns = 40;
      u_host.send(SYNC_BYTE, 8);
      ext_fault = 1'b1;
      cyc(10);
      ext_fault = 1'b0;
      u_host.send(8'h3C, 8);
      u_host.gap_ns = 0;
      cyc(20);
      chk("done after shared fault", 1'b0, c_oe);
      chk("chain after shared fault", 1'b1, chain_out_n);
      chk("fault line not held", 1'b1, f_oe);
      $display("test shared_fault done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      reset        = 1'b1;
      chain_in_n   = 1'b0;
      ext_fault    = 1'b0;
      ext_done_low = 1'b0;
      failures        = 0;
      samples_checked = 0;
      u_host.idle(2);
      cyc(6);
      reset = 1'b0;
      t_chain_off();
      t_good();
      t_bad_header();
      t_shared_fault();
      test_done();
   end

   // the whole run is some 2800 cycles
   initial begin
      repeat (30000) @(posedge ref_clk);
      failures++;
      $display("ERROR watchdog expected finish seen timeout");
      test_done();
   end
endmodule // tb_top
`default_nettype wire
